// ==== pslm_core.sv ====
// Pin select lock, key sequence, input mapping and output route registers
//
// Operation
// - Writes to mapping registers while locked are silently dropped.
// - Lock bit sits at oscillator control bit 6; one blocks writes.
// - Keys 0x46 then 0x57 to low byte precede one lock change write.
// - Lock holds its value until a new keyed write changes it.
// - Shadow copies of all mapping registers raise a mismatch reset.
// - Single session option stops a set lock from clearing again.
// - Under single session, only device reset clears a set lock.
// - Option unprogrammed means single session; programmed allows many.
// - Four input and eight output route registers exist.
// - Input field n selects pin n; code 11111 ties input to ground.
// - Input select fields reset to all ones.
// - Unimplemented bits read zero and ignore writes.
// - Input fields sit at their documented bit positions.
// - Output code 00000 leaves the pin on its default port logic.
`timescale 1ns/10ps
`default_nettype none
module pslm_core #(
  parameter int unsigned NumPins = pslm_pkg::NumPins
) (
  input wire logic clk,                      // System clock, 200 MHz
  input wire logic resetn,                   // Async reset, active low
  input wire logic [7:0] regAddr,            // Register address
  input wire logic [15:0] regWdata,          // Write data
  input wire logic regWrite,                 // Write strobe
  input wire logic regRead,                  // Read strobe
  output logic [15:0] regRdata,              // Read data, cycle after read
  input wire logic singleSessionOption,      // Config: one write session
  input wire logic [NumPins-1:0] pinIn,      // Remappable pin levels
  output pslm_pkg::pslm_periph_in_s periphIn, // Routed peripheral inputs
  output logic [pslm_pkg::NumOut*2-1:0][4:0] outSel, // Per pin output code
  output logic [pslm_pkg::NumOut*2-1:0] pinDefault, // Pin left to port logic
  output logic ioLocked,                     // Mapping lock state
  output logic mismatchReset                 // Configuration mismatch reset
);
  localparam int unsigned MapW = $bits(pslm_pkg::pslm_map_s);

  typedef struct packed {
    pslm_pkg::pslm_map_s map;
    logic lock;
    logic everSet;
    pslm_pkg::pslm_key_e key;
    logic [15:0] rdata;
    logic [2:0][NumPins-1:0] sync;
    logic [NumPins-1:0] pinLvl;
    pslm_pkg::pslm_periph_in_s pin;
  } pslm_core_s;

  pslm_core_s st_q, st_d;
  localparam int unsigned NumIn = $bits(pslm_pkg::pslm_periph_in_s);
  logic [NumPins-1:0] pinStable;
  logic [NumIn-1:0][pslm_pkg::FieldW-1:0] inSel;
  logic [NumIn-1:0] routed;
  logic mapWrite;
  logic lockWrite;
  logic mismatch;

  initial begin
    if (NumPins < 1 || NumPins > 16) begin
      $error("pslm_core: NumPins must be 1..16");
    end
  end

  function automatic pslm_pkg::pslm_map_s map_reset();
    pslm_pkg::pslm_map_s m;
    m.irq1 = pslm_pkg::InReset & pslm_pkg::MaskHi;
    m.irq2 = pslm_pkg::InReset & pslm_pkg::MaskLo;
    m.tmr = pslm_pkg::InReset & pslm_pkg::MaskBoth;
    m.cap = pslm_pkg::InReset & pslm_pkg::MaskBoth;
    m.outr = '0;
    for (int i = 0; i < pslm_pkg::NumOut; i++) begin
      m.outr[i] = pslm_pkg::OutReset;
    end
    return m;
  endfunction

  function automatic logic route(input logic [4:0] sel,
                                 input logic [NumPins-1:0] pins);
    logic r;
    r = 1'b0;
    if (sel != pslm_pkg::SelGround && sel < 5'(NumPins)) begin
      r = pins[sel[3:0]];
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // Pin input filter
  // ------------------------------------------------------------------
  // Disagreeing stages hold the old level rather than glitch to zero
  always_comb begin
    pinStable = st_q.pinLvl;
    for (int i = 0; i < NumPins; i++) begin
      if (st_q.sync[1][i] == st_q.sync[2][i]) begin
        pinStable[i] = st_q.sync[2][i];
      end
    end
  end

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  // lock gates mapping writes
  assign mapWrite = regWrite && !st_q.lock;
  assign lockWrite = regWrite && regAddr == pslm_pkg::AddrOscCtl;

  always_comb begin
    st_d = st_q;
    st_d.sync[0] = pinIn;
    st_d.sync[1] = st_q.sync[0];
    st_d.sync[2] = st_q.sync[1];
    st_d.pinLvl = pinStable;

    if (lockWrite) begin
      unique case (st_q.key)
        pslm_pkg::KeyIdle: begin
          st_d.key = (regWdata[7:0] == pslm_pkg::KeyFirst) ?
                     pslm_pkg::KeyGotFirst : pslm_pkg::KeyIdle;
        end
        pslm_pkg::KeyGotFirst: begin
          st_d.key = (regWdata[7:0] == pslm_pkg::KeySecond) ?
                     pslm_pkg::KeyArmed : pslm_pkg::KeyIdle;
        end
        pslm_pkg::KeyArmed: begin
          st_d.key = pslm_pkg::KeyIdle;
          if (regWdata[pslm_pkg::LockBit] ||
              !(singleSessionOption && st_q.everSet)) begin
            st_d.lock = regWdata[pslm_pkg::LockBit];
          end
          if (regWdata[pslm_pkg::LockBit]) begin
            st_d.everSet = 1'b1;
          end
        end
        default: begin
          st_d.key = pslm_pkg::KeyIdle;
        end
      endcase
    end else if (regWrite) begin
      st_d.key = pslm_pkg::KeyIdle;
    end

    if (mapWrite) begin
      unique case (regAddr)
        pslm_pkg::AddrInIrq1: st_d.map.irq1 = regWdata & pslm_pkg::MaskHi;
        pslm_pkg::AddrInIrq2: st_d.map.irq2 = regWdata & pslm_pkg::MaskLo;
        pslm_pkg::AddrInTmr: st_d.map.tmr = regWdata & pslm_pkg::MaskBoth;
        pslm_pkg::AddrInCap: st_d.map.cap = regWdata & pslm_pkg::MaskBoth;
        default: begin
          if (regAddr >= pslm_pkg::AddrOutBase &&
              regAddr <= pslm_pkg::AddrOutLast) begin
            st_d.map.outr[regAddr[2:0]] = regWdata & pslm_pkg::MaskBoth;
          end
        end
      endcase
    end

    // Register read, answered in the next cycle
    st_d.rdata = '0;
    if (regRead) begin
      unique case (regAddr)
        pslm_pkg::AddrOscCtl: begin
          st_d.rdata[pslm_pkg::LockBit] = st_q.lock;
        end
        pslm_pkg::AddrInIrq1: st_d.rdata = st_q.map.irq1;
        pslm_pkg::AddrInIrq2: st_d.rdata = st_q.map.irq2;
        pslm_pkg::AddrInTmr: st_d.rdata = st_q.map.tmr;
        pslm_pkg::AddrInCap: st_d.rdata = st_q.map.cap;
        default: begin
          if (regAddr >= pslm_pkg::AddrOutBase &&
              regAddr <= pslm_pkg::AddrOutLast) begin
            st_d.rdata = st_q.map.outr[regAddr[2:0]];
          end
        end
      endcase
    end

    st_d.pin = pslm_pkg::pslm_periph_in_s'(routed);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q.map.irq1 <= pslm_pkg::InReset & pslm_pkg::MaskHi;
      st_q.map.irq2 <= pslm_pkg::InReset & pslm_pkg::MaskLo;
      st_q.map.tmr <= pslm_pkg::InReset & pslm_pkg::MaskBoth;
      st_q.map.cap <= pslm_pkg::InReset & pslm_pkg::MaskBoth;
      st_q.map.outr <= '0;
      st_q.lock <= 1'b0;
      st_q.everSet <= 1'b0;
      st_q.key <= pslm_pkg::KeyIdle;
      st_q.rdata <= '0;
      st_q.sync <= '0;
      st_q.pinLvl <= '0;
      st_q.pin <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // Input routing
  // ------------------------------------------------------------------
  // field placement
  assign inSel[5] = st_q.map.irq1[pslm_pkg::HiLsb +: pslm_pkg::FieldW];
  assign inSel[4] = st_q.map.irq2[pslm_pkg::LoLsb +: pslm_pkg::FieldW];
  assign inSel[3] = st_q.map.tmr[pslm_pkg::LoLsb +: pslm_pkg::FieldW];
  assign inSel[2] = st_q.map.tmr[pslm_pkg::HiLsb +: pslm_pkg::FieldW];
  assign inSel[1] = st_q.map.cap[pslm_pkg::LoLsb +: pslm_pkg::FieldW];
  assign inSel[0] = st_q.map.cap[pslm_pkg::HiLsb +: pslm_pkg::FieldW];

  for (genvar c = 0; c < NumIn; c++) begin : g_in
    assign routed[c] = route(inSel[c], pinStable);
  end

  // ------------------------------------------------------------------
  // Shadow monitor
  // ------------------------------------------------------------------
  logic [MapW-1:0] liveXor;
  logic [MapW-1:0] nextXor;
  assign liveXor = st_q.map ^ map_reset();
  assign nextXor = st_d.map ^ map_reset();

  pslm_shadow #(
    .Width(MapW)
  ) u_shadow (
    .clk(clk),
    .resetn(resetn),
    .load(mapWrite),
    .nextVal(nextXor),
    .liveVal(liveXor),
    .rstVal(map_reset()),
    .mismatch(mismatch)
  );

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // eight output registers, two pins each
  for (genvar g = 0; g < pslm_pkg::NumOut * 2; g++) begin : g_out
    assign outSel[g] = st_q.map.outr[g / 2][(g % 2) * 8 +: 5];
    assign pinDefault[g] = (outSel[g] == pslm_pkg::SelNull);
  end

  assign regRdata = st_q.rdata;
  assign periphIn = st_q.pin;
  assign ioLocked = st_q.lock;
  assign mismatchReset = mismatch;
endmodule
`default_nettype wire

// ==== pslm_core_chk.sv ====
// Checker: lock sequence, lock hold and read data relations
`timescale 1ns/10ps
`default_nettype none
module pslm_core_chk (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic [7:0] regAddr, // Address
  input wire logic [15:0] regWdata, // Write data
  input wire logic regWrite, // Write strobe
  input wire logic regRead, // Read strobe
  input wire logic [15:0] regRdata, // Read data
  input wire logic singleSessionOption, // Single session
  input wire logic [pslm_pkg::NumOut*2-1:0][4:0] outSel, // Output codes
  input wire logic [pslm_pkg::NumOut*2-1:0] pinDefault, // Default pins
  input wire logic ioLocked, // Lock state
  input wire logic mismatchReset // Mismatch reset
);
  logic [1:0] keyQ, keyD;
  logic oscWr, armed;
  logic [15:0] defExp;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Key tracking
  // ----------------------------------------
  assign oscWr = regWrite && regAddr == pslm_pkg::AddrOscCtl;
  assign armed = oscWr && keyQ == 2'd2;
  always_comb begin
    keyD = keyQ;
    if (oscWr) begin
      if (keyQ == 2'd0 && regWdata[7:0] == pslm_pkg::KeyFirst)
        keyD = 2'd1;
      else if (keyQ == 2'd1 && regWdata[7:0] == pslm_pkg::KeySecond)
        keyD = 2'd2;
      else
        keyD = 2'd0;
    end else if (regWrite) begin
      keyD = 2'd0;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      keyQ <= 2'd0;
    else
      keyQ <= keyD;
  end
  always_comb begin
    for (int i = 0; i < 16; i++)
      defExp[i] = outSel[i] == 5'h00;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  lock_keyed_a: assert property ($changed(ioLocked) |-> $past(armed))
    else $error("lock changed without key sequence");
  lock_takes_a: assert property (
    armed && !(singleSessionOption && ioLocked)
    |=> ioLocked == $past(regWdata[pslm_pkg::LockBit]))
    else $error("lock did not take written bit");
  one_way_a: assert property (
    singleSessionOption && ioLocked |=> ioLocked)
    else $error("lock cleared under single session");
  lock_freeze_a: assert property (ioLocked |=> $stable(outSel))
    else $error("mapping changed while locked");
  no_mismatch_a: assert property (!mismatchReset)
    else $error("mismatch reset without disturbance");
  rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 16'h0000)
    else $error("read data outside read cycle");
  rd_unimpl_a: assert property (
    (regRdata & ~(pslm_pkg::MaskBoth | 16'h0040)) == 16'h0000)
    else $error("unimplemented bit read as one");
  pin_default_a: assert property (pinDefault == defExp)
    else $error("pin default flag wrong");
  cover property ($rose(ioLocked));
  cover property ($fell(ioLocked));
  cover property (regRead && regAddr == pslm_pkg::AddrInCap);
endmodule
bind pslm_core pslm_core_chk u_chk (.clk, .resetn, .regAddr, .regWdata,
  .regWrite, .regRead, .regRdata, .singleSessionOption, .outSel,
  .pinDefault, .ioLocked, .mismatchReset);
`default_nettype wire

// ==== pslm_pkg.sv ====
// Package: register map, field layout and constants for pin select lock
package pslm_pkg;
  localparam int unsigned AddrW = 8;
  localparam int unsigned DataW = 16;
  localparam int unsigned FieldW = 5;
  localparam int unsigned NumPins = 16;
  localparam int unsigned NumOut = 8;

  localparam logic [7:0] AddrOscCtl = 8'h00;
  localparam logic [7:0] AddrInIrq1 = 8'h10;
  localparam logic [7:0] AddrInIrq2 = 8'h11;
  localparam logic [7:0] AddrInTmr = 8'h13;
  localparam logic [7:0] AddrInCap = 8'h17;
  localparam logic [7:0] AddrOutBase = 8'h20;
  localparam logic [7:0] AddrOutLast = 8'h27;

  localparam int unsigned LockBit = 6;
  localparam logic [7:0] KeyFirst = 8'h46;
  localparam logic [7:0] KeySecond = 8'h57;

  localparam int unsigned HiLsb = 8;
  localparam int unsigned LoLsb = 0;
  localparam logic [15:0] MaskHi = 16'h1f00;
  localparam logic [15:0] MaskLo = 16'h001f;
  localparam logic [15:0] MaskBoth = 16'h1f1f;
  localparam logic [15:0] InReset = 16'h1f1f;
  localparam logic [15:0] OutReset = 16'h0000;
  localparam logic [4:0] SelGround = 5'h1f;
  localparam logic [4:0] SelNull = 5'h00;

  typedef enum logic [1:0] {KeyIdle, KeyGotFirst, KeyArmed} pslm_key_e;

  typedef struct packed {
    logic [15:0] irq1;
    logic [15:0] irq2;
    logic [15:0] tmr;
    logic [15:0] cap;
    logic [NumOut-1:0][15:0] outr;
  } pslm_map_s;

  typedef struct packed {
    logic extIrq1;
    logic extIrq2;
    logic timer2Clk;
    logic timer3Clk;
    logic capture1;
    logic capture2;
  } pslm_periph_in_s;
endpackage

// ==== pslm_shadow.sv ====
// Shadow copy of the mapping registers with continuous comparison
`timescale 1ns/10ps
`default_nettype none
module pslm_shadow #(
  parameter int unsigned Width = 192
) (
  input wire logic clk,                 // System clock
  input wire logic resetn,              // Async reset, active low
  input wire logic load,                // Register write while unlocked, any address, this cycle
  input wire logic [Width-1:0] nextVal, // Value the mapping takes next
  input wire logic [Width-1:0] liveVal, // Present mapping contents
  input wire logic [Width-1:0] rstVal,  // Mapping reset image
  output logic mismatch                 // Registered compare failure
);
  typedef struct packed {
    logic [Width-1:0] copy;
    logic miss;
  } pslm_shadow_s;

  pslm_shadow_s st_q, st_d;

  initial begin
    if (Width == 0) begin
      $error("pslm_shadow: Width must be non-zero");
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.miss = (liveVal != st_q.copy);
    if (load) begin
      st_d.copy = nextVal;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q.copy <= '0;
      st_q.miss <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Copy starts as zero; the core folds the reset image into both
  // compare inputs so the first compare after reset is clean
  assign mismatch = st_q.miss;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Testbench: bus tasks, reference model and scenarios
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, resetn, regWrite, regRead, opt, ioLocked, mismatchReset, lk;
  logic [7:0] regAddr;
  logic [15:0] regWdata, regRdata, pinIn, pinDefault;
  logic [15:0][4:0] outSel;
  pslm_pkg::pslm_periph_in_s periphIn, pe;
  logic [15:0] m[256];
  logic [7:0] ad[12] = '{8'h10, 8'h11, 8'h13, 8'h17, 8'h20, 8'h21, 8'h22,
    8'h23, 8'h24, 8'h25, 8'h26, 8'h27};
  int key, miscompares, n_tests;
  pslm_core dut (.clk, .resetn, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .singleSessionOption(opt), .pinIn, .periphIn, .outSel,
    .pinDefault, .ioLocked, .mismatchReset);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // Model and bus tasks
  // ----------------------------------------
  function automatic logic [15:0] msk(input logic [7:0] a);
    case (a)
      pslm_pkg::AddrInIrq1: msk = pslm_pkg::MaskHi;
      pslm_pkg::AddrInIrq2: msk = pslm_pkg::MaskLo;
      pslm_pkg::AddrInTmr, pslm_pkg::AddrInCap: msk = pslm_pkg::MaskBoth;
      default: msk = (a >= pslm_pkg::AddrOutBase &&
        a <= pslm_pkg::AddrOutLast) ? pslm_pkg::MaskBoth : 16'h0000;
    endcase
  endfunction
  function automatic logic pk(input logic [4:0] s);
    pk = s < 5'd16 ? pinIn[s[3:0]] : 1'b0;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    @(posedge clk);
    if (a == pslm_pkg::AddrOscCtl) begin
      if (key == 2 && !(opt && lk)) lk = d[pslm_pkg::LockBit];
      if (key == 0 && d[7:0] == pslm_pkg::KeyFirst) key = 1;
      else if (key == 1 && d[7:0] == pslm_pkg::KeySecond) key = 2;
      else key = 0;
    end else begin
      key = 0;
      if (!lk) m[a] = d & msk(a);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    regWrite <= 1'b0;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk("rdata", a == 8'h00 ? {9'h0, lk, 6'h0} : m[a], regRdata);
    @(posedge clk);
  endtask
  task automatic idle();
    regWrite <= 1'b0;
    regRead <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rst(input logic o);
    resetn <= 1'b0;
    opt <= o;
    regWrite <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    lk = 1'b0;
    key = 0;
    for (int i = 0; i < 256; i++)
      m[i] = 16'h1f1f & msk(8'(i)) & ((i < 32) ? 16'hffff : 16'h0);
  endtask
  task automatic lock(input logic v);
    wr(8'h00, 16'h0046);
    wr(8'h00, 16'h0057);
    wr(8'h00, {9'h0, v, 6'h0});
  endtask
  task automatic fill(input logic [15:0] mk);
    for (int i = 0; i < 12; i++)
      wr(ad[i], 16'($urandom) & mk);
  endtask
  task automatic chkall();
    logic [4:0] e;
    idle();
    for (int a = 0; a < 256; a++)
      rd(8'(a));
    for (int k = 0; k < 16; k++) begin
      e = m[32 + k / 2][(k % 2) * 8 +: 5];
      chk("outSel", {11'h0, e}, {11'h0, outSel[k]});
      chk("pinDefault", {15'h0, !(|e)}, {15'h0, pinDefault[k]});
    end
    chk("lock", {15'h0, lk}, {15'h0, ioLocked});
    chk("mismatchReset", 16'h0000, {15'h0, mismatchReset});
  endtask
  task automatic route();
    pinIn <= 16'($urandom);
    repeat (8) @(posedge clk);
    pe.extIrq1 = pk(m[16][12:8]);
    pe.extIrq2 = pk(m[17][4:0]);
    pe.timer3Clk = pk(m[19][12:8]);
    pe.timer2Clk = pk(m[19][4:0]);
    pe.capture2 = pk(m[23][12:8]);
    pe.capture1 = pk(m[23][4:0]);
    chk("periphIn", {10'h0, pe}, {10'h0, periphIn});
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    opt = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 16'h0000;
    pinIn = 16'h0000;
    miscompares = 0;
    n_tests = 0;
    void'($urandom(32'h0b0a));
    rst(1'b1);
    chkall();
    for (int r = 0; r < 4; r++) begin
      fill(r[0] ? 16'hffff : 16'h0f0f);
      chkall();
      repeat (3) route();
    end
    lock(1'b1);
    fill(16'hffff);
    chkall();
    lock(1'b0);
    fill(16'hffff);
    chkall();
    rst(1'b1);
    fill(16'h0f0f);
    chkall();
    rst(1'b0);
    lock(1'b1);
    lock(1'b0);
    fill(16'hffff);
    fill(16'h0f0f);
    chkall();
    wr(8'h00, 16'h0046);
    wr(8'h00, 16'h0011);
    wr(8'h00, 16'h0057);
    wr(8'h00, 16'h0040);
    wr(8'h00, 16'h0046);
    wr(8'h10, 16'h0300);
    wr(8'h00, 16'h0057);
    wr(8'h00, 16'h0040);
    wr(8'h00, 16'h0046);
    wr(8'h00, 16'h0046);
    wr(8'h00, 16'h0057);
    wr(8'h00, 16'h0040);
    fill(16'hffff);
    chkall();
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
